// >>> hdl/dsc_capture_top.sv
/*
 * dsc_capture_top: data path of a double-data-rate memory port.
 * Per byte group a delayed strobe captures read data on both edges,
 * a dual-clock fifo brings the word pairs to sys_clk, and a
 * phase-shifted pll clock launches write data and enables.
 * assumes: dqs_dly_clk arrives already delayed by the tap setting on
 * dly_tap and sits on a global clock net; wr_* inputs are timed to
 * pll_wr_clk; the strobe only toggles during read bursts.
 */
// Functional notes
// R1: a group is one strobe, eight data pins, one mask; strobe times them.
// R2: up to eight identical byte groups, count set by parameter.
// R3: strobe delay of quarter period for ddr, 72 degrees for fcram.
// R4: delayed strobe reaches capture as a global clock, not a local one.
// R5: read data captured in core registers clocked by its group strobe.
// R6: write data and data enables launched from the pll write clock.
// R7: captured data resynchronised to the core clock through a fifo.
// R8: capture on both strobe edges, two words per strobe period.
`timescale 1ns/10ps

module dsc_capture_top
    import dsc_pkg::*;
#(
    parameter int NUM_GRP = GRP_MAX,
    parameter int DEPTH = FIFO_DEPTH
)(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [NUM_GRP-1:0] dqs_dly_clk,
    input wire logic [NUM_GRP-1:0][DQ_W-1:0] dq_pin_rx,
    output logic [NUM_GRP-1:0][DQ_W-1:0] dq_pin_tx,
    output logic [NUM_GRP-1:0][DQ_W-1:0] dq_pin_oe,
    output logic [NUM_GRP-1:0] dm_pin_tx,
    output logic [NUM_GRP-1:0] dm_pin_oe,
    input wire logic pll_wr_clk,
    input wire logic [NUM_GRP-1:0][DQ_W-1:0] wr_dq,
    input wire logic [NUM_GRP-1:0] wr_dm,
    input wire logic wr_drive,
    input wire dsc_mem_t mem_type,
    output logic [NUM_GRP-1:0][TAP_W-1:0] dly_tap,
    output logic [NUM_GRP-1:0][2*DQ_W-1:0] rd_data,
    output logic [NUM_GRP-1:0] rd_valid,
    input wire logic [NUM_GRP-1:0] rd_ready,
    output logic [NUM_GRP-1:0] cap_full,
    output logic [NUM_GRP-1:0] ovr_flag,
    input wire logic [NUM_GRP-1:0] ovr_clear
);

    // ========================================================
    // state of the sys_clk domain
    typedef struct packed {
        logic [NUM_GRP-1:0][TAP_W-1:0] tap;
        logic [NUM_GRP-1:0][2*DQ_W-1:0] data;
        logic [NUM_GRP-1:0] valid;
        logic [NUM_GRP-1:0] rdy_s1;
        logic [NUM_GRP-1:0] rdy_s2;
        logic [NUM_GRP-1:0] full;
        logic [NUM_GRP-1:0] ovr_s1;
        logic [NUM_GRP-1:0] ovr_s2;
        logic [NUM_GRP-1:0] ovr_s3;
        logic [NUM_GRP-1:0] ovr;
    } dsc_sys_t;

    // ========================================================
    // state of the pll write domain
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic [NUM_GRP-1:0][DQ_W-1:0] dq;
        logic [NUM_GRP-1:0][DQ_W-1:0] oe;
        logic [NUM_GRP-1:0] dm;
        logic [NUM_GRP-1:0] dm_oe;
    } dsc_pll_t;

    dsc_sys_t s_q, s_d;
    dsc_pll_t p_q, p_d;

    logic [NUM_GRP-1:0] wready_w;
    logic [NUM_GRP-1:0] ovr_tgl_w;
    logic [NUM_GRP-1:0] rvalid_w;
    logic [NUM_GRP-1:0][2*DQ_W-1:0] rdata_w;
    logic [NUM_GRP-1:0] pop_w;

    // ========================================================
    // delay chain setting per memory kind
    function automatic logic [TAP_W-1:0] tap_for(input dsc_mem_t kind);
        logic [TAP_W-1:0] t;
        t = TAP_DDR;
        if (kind == DSC_MEM_FCRAM) begin
            t = TAP_FCRAM;
        end
        return t;
    endfunction

    // ========================================================
    // per group strobe domain and fifo
    // every group is the same slice; only the strobe differs
    for (genvar g = 0; g < NUM_GRP; g++) begin : grp // R2
        dsc_fifo_if #(.W(2*DQ_W)) fif ();
        logic fall_clk;
        logic [DQ_W-1:0] rise_q;
        logic tgl_q;

        // the fall edge closes a pair, so the pair is written then
        // and nothing waits on an edge after the burst ends
        assign fall_clk = ~dqs_dly_clk[g]; // R4

        // rising half of the pair, timed only by this group strobe
        always_ff @(posedge dqs_dly_clk[g]) begin // R1
            rise_q <= dq_pin_rx[g]; // R5
        end

        assign fif.push = 1'b1;
        assign fif.wdata = {rise_q, dq_pin_rx[g]}; // R8

        // a pair that meets a full fifo is lost; flip a toggle so
        // the core side can see it across the crossing
        always_ff @(posedge fall_clk) begin
            if (fif.wr_rst) begin
                tgl_q <= 1'b0;
            end else if (!fif.wready) begin
                tgl_q <= ~tgl_q;
            end
        end

        assign wready_w[g] = fif.wready;
        assign ovr_tgl_w[g] = tgl_q;
        assign rvalid_w[g] = fif.rvalid;
        assign rdata_w[g] = fif.rdata;
        assign fif.pop = pop_w[g];

        dsc_fifo #(
            .W(2*DQ_W),
            .DEPTH(DEPTH)
        ) u_fifo (
            .wclk(fall_clk),
            .rclk(sys_clk),
            .resetn(resetn),
            .wr(fif.fifo_wr),
            .rd(fif.fifo_rd)
        ); // R7
    end

    // ========================================================
    // core side: output stage, crossings, tap setting
    // the output stage holds one pair so rd_data comes from a flop
    always_comb begin
        pop_w = rvalid_w & (~s_q.valid | rd_ready); // R7
    end

    always_comb begin
        s_d = s_q;
        for (int g = 0; g < NUM_GRP; g++) begin
            s_d.tap[g] = tap_for(mem_type); // R3

            // fifo ready is a level; the inverted copy is cap_full
            s_d.rdy_s1[g] = wready_w[g];
            s_d.rdy_s2[g] = s_q.rdy_s1[g];
            s_d.full[g] = ~s_q.rdy_s2[g];

            // overrun event: toggle crossing, edge taken past stage 2
            s_d.ovr_s1[g] = ovr_tgl_w[g];
            s_d.ovr_s2[g] = s_q.ovr_s1[g];
            s_d.ovr_s3[g] = s_q.ovr_s2[g];
            if (ovr_clear[g]) begin
                s_d.ovr[g] = 1'b0;
            end
            // a loss seen in the clearing cycle still sets the flag
            if (s_q.ovr_s2[g] ^ s_q.ovr_s3[g]) begin
                s_d.ovr[g] = 1'b1;
            end

            if (pop_w[g]) begin
                s_d.valid[g] = 1'b1;
                s_d.data[g] = rdata_w[g]; // R7
            end else if (rd_ready[g]) begin
                s_d.valid[g] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dly_tap = s_q.tap;
    assign rd_data = s_q.data;
    assign rd_valid = s_q.valid;
    assign cap_full = s_q.full;
    assign ovr_flag = s_q.ovr;

    // ========================================================
    // write launch on the phase-shifted pll clock
    // the strobe never clocks this path, so write timing does not
    // depend on the read delay setting
    always_comb begin
        p_d = p_q;
        p_d.rst_s1 = ~resetn;
        p_d.rst_s2 = p_q.rst_s1;
        for (int g = 0; g < NUM_GRP; g++) begin
            p_d.dq[g] = wr_dq[g]; // R6
            p_d.dm[g] = wr_dm[g];
            p_d.oe[g] = {DQ_W{wr_drive}}; // R6
            p_d.dm_oe[g] = wr_drive;
        end
        if (p_q.rst_s2) begin
            p_d.dq = '0;
            p_d.dm = '0;
            p_d.oe = '0;
            p_d.dm_oe = '0;
        end
    end

    always_ff @(posedge pll_wr_clk) begin
        p_q <= p_d;
    end

    assign dq_pin_tx = p_q.dq;
    assign dq_pin_oe = p_q.oe;
    assign dm_pin_tx = p_q.dm;
    assign dm_pin_oe = p_q.dm_oe;

endmodule // dsc_capture_top

// >>> hdl/dsc_fifo.sv
/*
 * dsc_fifo: dual-clock fifo with gray-coded pointers.
 * assumes: DEPTH is a power of two, at least 4; wclk must toggle
 * while resetn is low so the write side leaves reset cleanly.
 */
`timescale 1ns/10ps

module dsc_fifo
    import dsc_pkg::*;
#(
    parameter int W = 2 * DQ_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input wire logic wclk,
    input wire logic rclk,
    input wire logic resetn,
    dsc_fifo_if.fifo_wr wr,
    dsc_fifo_if.fifo_rd rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] peer_s1;
        logic [AW:0] peer_s2;
        logic rst_s1;
        logic rst_s2;
    } dsc_ptr_t;

    logic [W-1:0] mem [DEPTH];
    dsc_ptr_t w_q, w_d, r_q, r_d;
    logic full, empty, do_wr, do_rd;
    logic [AW:0] wnext, rnext;

    // ========================================================
    // write side, strobe domain
    // reset is carried over by two flops; it only acts on strobe edges
    // limitation: the read pointer is only seen on strobe edges, so
    // after a drain the next burst still meets a stale full for two pairs
    assign full = (w_q.gray ==
        {~w_q.peer_s2[AW:AW-1], w_q.peer_s2[AW-2:0]});
    assign wr.wready = ~full & ~w_q.rst_s2;
    assign wr.wr_rst = w_q.rst_s2;
    assign do_wr = wr.push & wr.wready;
    assign wnext = w_q.bin + (AW+1)'(1);

    always_comb begin
        w_d = w_q;
        w_d.rst_s1 = ~resetn;
        w_d.rst_s2 = w_q.rst_s1;
        w_d.peer_s1 = r_q.gray;
        w_d.peer_s2 = w_q.peer_s1;
        if (do_wr) begin
            w_d.bin = wnext;
            w_d.gray = wnext ^ (wnext >> 1);
        end
        if (w_q.rst_s2) begin
            w_d.bin = '0;
            w_d.gray = '0;
        end
    end

    always_ff @(posedge wclk) begin
        w_q <= w_d;
        if (do_wr) begin
            mem[w_q.bin[AW-1:0]] <= wr.wdata;
        end
    end

    // ========================================================
    // read side, sys_clk domain
    assign empty = (r_q.gray == r_q.peer_s2);
    assign rd.rvalid = ~empty;
    assign rd.rdata = mem[r_q.bin[AW-1:0]];
    assign do_rd = rd.pop & ~empty;
    assign rnext = r_q.bin + (AW+1)'(1);

    always_comb begin
        r_d = r_q;
        r_d.rst_s1 = 1'b0;
        r_d.rst_s2 = 1'b0;
        r_d.peer_s1 = w_q.gray;
        r_d.peer_s2 = r_q.peer_s1;
        if (do_rd) begin
            r_d.bin = rnext;
            r_d.gray = rnext ^ (rnext >> 1);
        end
    end

    always_ff @(posedge rclk) begin
        if (!resetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
endmodule // dsc_fifo

// >>> hdl/dsc_fifo_if.sv
/*
 * dsc_fifo_if: write and read handshake of one capture fifo.
 * assumes: write signals live on the strobe domain, read on sys_clk.
 */
`timescale 1ns/10ps

interface dsc_fifo_if #(parameter int W = 16);
    logic push;
    logic [W-1:0] wdata;
    logic wready;
    logic wr_rst;
    logic rvalid;
    logic [W-1:0] rdata;
    logic pop;

    modport src (output push, output wdata, input wready, input wr_rst);
    modport snk (input rvalid, input rdata, output pop);
    modport fifo_wr (input push, input wdata, output wready,
        output wr_rst);
    modport fifo_rd (output rvalid, output rdata, input pop);
endinterface

// >>> hdl/dsc_pkg.sv
/*
 * dsc_pkg: shared constants and types of the strobe capture path.
 * assumes: imported whole by every design module of the block.
 */
package dsc_pkg;

    // ========================================================
    // group geometry
    localparam int GRP_MAX = 8;
    localparam int DQ_W = 8;
    localparam int FIFO_DEPTH = 8;

    // ========================================================
    // strobe delay chain
    localparam int TAP_W = 5;
    localparam int TAPS_PER_PERIOD = 20;
    localparam int DEG_PER_PERIOD = 360;
    localparam int PHASE_DDR_DEG = 90;
    localparam int PHASE_FCRAM_DEG = 72;
    localparam logic [TAP_W-1:0] TAP_DDR =
        TAP_W'(TAPS_PER_PERIOD * PHASE_DDR_DEG / DEG_PER_PERIOD);
    localparam logic [TAP_W-1:0] TAP_FCRAM =
        TAP_W'(TAPS_PER_PERIOD * PHASE_FCRAM_DEG / DEG_PER_PERIOD);

    // ========================================================
    // memory kinds
    typedef enum logic {
        DSC_MEM_DDR,
        DSC_MEM_FCRAM
    } dsc_mem_t;

endpackage

// >>> verif/dsc_capture_top_chk.sv
/* dsc_capture_top_chk: port timing checks of the capture path.
 * assumes: bound into dsc_capture_top; resetn starts low. */
`timescale 1ns/10ps
module dsc_capture_top_chk
    import dsc_pkg::*;
#(
    parameter int NUM_GRP = GRP_MAX
)(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic pll_wr_clk,
    input wire logic [NUM_GRP-1:0][DQ_W-1:0] wr_dq,
    input wire logic wr_drive,
    input wire logic [NUM_GRP-1:0][DQ_W-1:0] dq_pin_tx,
    input wire logic [NUM_GRP-1:0][DQ_W-1:0] dq_pin_oe,
    input wire logic [NUM_GRP-1:0] dm_pin_oe,
    input wire dsc_mem_t mem_type,
    input wire logic [NUM_GRP-1:0][TAP_W-1:0] dly_tap,
    input wire logic [NUM_GRP-1:0][2*DQ_W-1:0] rd_data,
    input wire logic [NUM_GRP-1:0] rd_valid,
    input wire logic [NUM_GRP-1:0] rd_ready,
    input wire logic [NUM_GRP-1:0] cap_full,
    input wire logic [NUM_GRP-1:0] ovr_flag,
    input wire logic [NUM_GRP-1:0] ovr_clear
);
    // ========================================================
    // core clock side
    a_tap_ddr: assert property (@(posedge sys_clk)
        disable iff (!resetn) mem_type == DSC_MEM_DDR
        |=> dly_tap == {NUM_GRP{TAP_DDR}}) else $error("ddr tap");
    a_tap_fcram: assert property (@(posedge sys_clk)
        disable iff (!resetn) mem_type == DSC_MEM_FCRAM
        |=> dly_tap == {NUM_GRP{TAP_FCRAM}}) else $error("fcram tap");
    a_grp_same: assert property (@(posedge sys_clk)
        disable iff (!resetn) rd_valid[0] |-> rd_valid[NUM_GRP-1])
        else $error("groups out of step");
    a_rd_hold: assert property (@(posedge sys_clk)
        disable iff (!resetn) rd_valid[0] && !rd_ready[0]
        |=> rd_valid[0] && $stable(rd_data[0])) else $error("pair lost");
    a_ovr_sticky: assert property (@(posedge sys_clk)
        disable iff (!resetn) ovr_flag[0] && !ovr_clear[0] |=> ovr_flag[0])
        else $error("overrun flag dropped");
    // set wins over clear, so only a quiet fifo makes clear binding
    a_ovr_clear: assert property (@(posedge sys_clk)
        disable iff (!resetn) ovr_clear[0] && !cap_full[0]
        && $past(cap_full[0], 2) == 1'b0 |=> !ovr_flag[0])
        else $error("overrun flag not cleared");
    // ========================================================
    // write clock side, then covers on both clocks
    a_wr_data: assert property (@(posedge pll_wr_clk)
        disable iff (!resetn) wr_drive |=> dq_pin_tx == $past(wr_dq))
        else $error("write data wrong");
    a_oe_on: assert property (@(posedge pll_wr_clk)
        disable iff (!resetn) wr_drive
        |=> dq_pin_oe == '1 && dm_pin_oe == '1) else $error("oe low");
    a_oe_off: assert property (@(posedge pll_wr_clk)
        disable iff (!resetn) !wr_drive
        |=> dq_pin_oe == '0 && dm_pin_oe == '0) else $error("oe high");
    c_pop: cover property (@(posedge sys_clk) rd_valid[0] && rd_ready[0]);
    c_full: cover property (@(posedge sys_clk) $rose(ovr_flag[0]));
    c_drive: cover property (@(posedge pll_wr_clk) wr_drive);
endmodule // dsc_capture_top_chk

bind dsc_capture_top dsc_capture_top_chk #(.NUM_GRP(NUM_GRP)) u_chk (
    .sys_clk, .resetn, .pll_wr_clk, .wr_dq, .wr_drive, .dq_pin_tx,
    .dq_pin_oe, .dm_pin_oe, .mem_type, .dly_tap, .rd_data, .rd_valid,
    .rd_ready, .cap_full, .ovr_flag, .ovr_clear);

// >>> verif/dsc_capture_top_test.sv
/* dsc_capture_top_test: directed scenarios for the capture path.
 * assumes: dsc_mem_model plays the memory; the checker is bound in. */
`timescale 1ns/10ps
module dsc_capture_top_test
    import dsc_pkg::*;
;
    // ========================================================
    // harness
    localparam int NG = 2;
    logic sys_clk = 0, pll_wr_clk = 1, resetn = 0, wr_drive = 0;
    logic [NG-1:0] dqs, wr_dm = '0, dm_pin_tx, dm_pin_oe, rd_valid;
    logic [NG-1:0] rd_ready = '0, cap_full, ovr_flag, ovr_clear = '0;
    logic [NG-1:0][DQ_W-1:0] dq, dq_pin_tx, dq_pin_oe, wr_dq = '0;
    logic [NG-1:0][TAP_W-1:0] dly_tap;
    logic [NG-1:0][2*DQ_W-1:0] rd_data;
    dsc_mem_t mem_type = DSC_MEM_DDR;
    int err_total = 0, cmp_count = 0;
    always #20 sys_clk = ~sys_clk;
    always #20 pll_wr_clk = ~pll_wr_clk;
    dsc_mem_model #(.NUM_GRP(NG)) mem (.dqs, .dq);
    dsc_capture_top #(.NUM_GRP(NG), .DEPTH(FIFO_DEPTH)) DUT (
        .sys_clk, .resetn, .dqs_dly_clk(dqs), .dq_pin_rx(dq), .dq_pin_tx,
        .dq_pin_oe, .dm_pin_tx, .dm_pin_oe, .pll_wr_clk, .wr_dq, .wr_dm,
        .wr_drive, .mem_type, .dly_tap, .rd_data, .rd_valid, .rd_ready,
        .cap_full, .ovr_flag, .ovr_clear);
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #2;
    endtask
    function automatic logic [31:0] pair(input logic [7:0] b, input int k);
        for (int g = 0; g < NG; g++) begin
            pair[16*g +: 16] = {8'(b + 2*k + g), 8'(b + 2*k + 1 + g)};
        end
    endfunction
    task automatic pop(input logic [7:0] b, input int k);
        for (int i = 0; i < 40 && rd_valid !== '1; i++) begin
            tick();
        end
        if (rd_valid !== '1) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, rd_valid, 2'h3);
            wrap_up();
        end
        chk(rd_data, pair(b, k));
        rd_ready = '1;
        tick();
        rd_ready = '0;
        tick();
    endtask
    task automatic flush();
        rd_ready = '1;
        repeat (30) tick();
        rd_ready = '0;
    endtask
    // ========================================================
    // scenarios
    task automatic t_tap();
        mem_type = DSC_MEM_FCRAM;
        repeat (2) tick();
        chk(dly_tap, {NG{TAP_W'(20 * 72 / 360)}});
        mem_type = DSC_MEM_DDR;
        repeat (2) tick();
        chk(dly_tap, {NG{TAP_W'(20 * 90 / 360)}});
    endtask
    task automatic t_read();
        mem.burst(3, 8'h10);
        tick();
        for (int k = 0; k < 3; k++) pop(8'h10, k);
        tick();
        chk(rd_valid, '0);
    endtask
    // the output stage holds one pair beyond the fifo depth
    task automatic t_ovr();
        mem.burst(FIFO_DEPTH + 3, 8'h40);
        repeat (8) tick();
        chk({cap_full, ovr_flag}, 32'h0000000f);
        for (int k = 0; k <= FIFO_DEPTH; k++) pop(8'h40, k);
        chk(rd_valid, '0);
        mem.burst(3, 8'h80);
        tick();
        flush();
        chk({cap_full, rd_valid}, '0);
        ovr_clear = '1;
        tick();
        ovr_clear = '0;
        chk(ovr_flag, '0);
    endtask
    task automatic t_write();
        @(posedge pll_wr_clk);
        #2;
        wr_drive = 1'b1;
        wr_dq = {8'h5a, 8'ha5};
        wr_dm = 2'h1;
        @(posedge pll_wr_clk);
        #2;
        wr_drive = 1'b0;
        chk({dq_pin_tx, dm_pin_tx}, {16'h5aa5, 2'h1});
        chk({dq_pin_oe, dm_pin_oe}, 32'h0003ffff);
        @(posedge pll_wr_clk);
        #2;
        chk({dq_pin_oe, dm_pin_oe}, '0);
    endtask
    initial begin
        fork
            mem.burst(3, 8'h00);
            repeat (6) @(posedge sys_clk);
        join
        chk({rd_valid, ovr_flag, cap_full, dly_tap}, '0);
        tick();
        resetn = 1'b1;
        mem.burst(2, 8'h00);
        tick();
        flush();
        t_tap();
        t_read();
        t_ovr();
        t_write();
        wrap_up();
    end
endmodule // dsc_capture_top_test

// >>> verif/dsc_mem_model.sv
/* dsc_mem_model: memory side of the read path, strobe already delayed.
 * assumes: driven by task calls from the bench; strobe rests low. */
`timescale 1ns/10ps
module dsc_mem_model
    import dsc_pkg::*;
#(
    parameter int NUM_GRP = 2
)(
    output logic [NUM_GRP-1:0] dqs,
    output logic [NUM_GRP-1:0][DQ_W-1:0] dq
);
    // ========================================================
    // read bursts
    initial begin
        dqs = '0;
        dq = '0;
    end
    // n pairs from base b; 80 ns strobe, data turns mid-way between edges
    task automatic burst(input int n, input logic [DQ_W-1:0] b);
        #7;
        for (int k = 0; k < 2*n; k++) begin
            for (int g = 0; g < NUM_GRP; g++) begin
                dq[g] = b + DQ_W'(k + g);
            end
            #20;
            dqs = ~dqs;
            #20;
        end
        // hold time over: lines no longer show the last word
        for (int g = 0; g < NUM_GRP; g++) begin
            dq[g] = ~dq[g];
        end
    endtask
endmodule // dsc_mem_model
